// [shared/stxp_map.svh]
// offsets, field positions, reset values and timing counts of the transmit coding path
// Behaviour
// RULE1: byte serializer, when on, splits each wide word into two half words on consecutive cycles
// RULE2: byte serializer is needed above the fabric clock limit, otherwise optional by configuration
// RULE3: lower half of the wide word goes out first, upper half next
// RULE4: enabled encoder turns byte plus control flag into 10-bit group with correct disparity
// RULE5: control flag low gives a data group, high gives a special group
// RULE6: sender raises control flag only for valid special characters
// RULE7: during transmit reset encoder ignores inputs and repeats negative-disparity K28.5
// RULE8: after reset release start negative and send three K28.5 before any data
// RULE9: a few undefined words may precede the three commas after reset release
// RULE10: force-disparity input picks disparity from value input, low positive, high negative
// RULE11: polarity inversion flips every bit entering serializer, may change at any time
// RULE12: far receiver tolerates disparity errors caused by toggling polarity inversion
// RULE13: bit reversal rewires serializer input end to end for 8 and 10 bits
// RULE14: input bit-flip reverses bits within each byte before the input buffer
// RULE15: data to serializer is delayed by the bit-slip amount in bit positions
// RULE16: serializer sends bit 0 first and most significant bit last
// RULE17: serializer sends one bit per half-rate clock edge, two per clock
// RULE18: fabric side 8, 10, 16 or 20 bits, internal path 8 or 10 bits
// RULE19: after a forced word running disparity follows the group actually sent
`ifndef STXP_MAP_SVH
`define STXP_MAP_SVH
`define STXP_ADDR_CTRL      8'h00
`define STXP_ADDR_SLIP      8'h04
`define STXP_ADDR_STATUS    8'h08
`define STXP_CTRL_RST       32'h0000_0006
`define STXP_CTRL_BYTESER   0
`define STXP_CTRL_ENC       1
`define STXP_CTRL_WIDTH10   2
`define STXP_CTRL_BITREV    3
`define STXP_CTRL_BITFLIP   4
`define STXP_CTRL_POLINV    5
`define STXP_SLIP_RST       4'h0
`define STXP_K285_NEG       10'h17c
`define STXP_K285_POS       10'h283
`define STXP_K285_BYTE      8'hbc
`define STXP_SYNC_COMMAS    2'h3
`define STXP_LAST_PAIR10    3'h4
`define STXP_LAST_PAIR8     3'h3
`endif

// [shared/stxp_pkg.sv]
// types and shared coding functions of the transmit coding path
package stxp_pkg;
  typedef struct packed {
    logic [19:0] data;
    logic [1:0]  ctrl;
    logic [1:0]  force_disp;
    logic [1:0]  disp_val;
  } stxp_word_s;

  typedef struct packed {
    logic       polinv;
    logic       bitflip;
    logic       bitrev;
    logic       width10;
    logic       enc;
    logic       byteser;
    logic [3:0] slip;
  } stxp_cfg_s;

  typedef struct packed {
    stxp_cfg_s   cfg;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic [2:0]  pair_cnt;
    logic        half;
    logic [1:0]  commas;
    logic        rd;
    logic [9:0]  enc;
    logic [9:0]  prev;
    logic [7:0]  shift;
    logic [1:0]  ser_out;
  } stxp_state_s;

  function automatic logic [7:0] stxp_rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  function automatic logic [9:0] stxp_rev10(input logic [9:0] v);
    logic [9:0] r;
    for (int i = 0; i < 10; i++)
    begin
      r[i] = v[9-i];
    end
    return r;
  endfunction

  // returns {running disparity after, code group with bit 0 sent first}; rd 1 = positive
  function automatic logic [10:0] stxp_encode(input logic [7:0] d, input logic k, input logic rd);
    logic [5:0] t6;
    logic [3:0] t4;
    logic [4:0] x;
    logic [2:0] y;
    logic       k28;
    logic       unbal6;
    logic       unbal4;
    logic       rd1;
    logic       alt7;
    x = d[4:0];
    y = d[7:5];
    k28 = k && (x == 5'h1c);
    case (x)
      5'h00: t6 = 6'h27;  5'h01: t6 = 6'h1d;  5'h02: t6 = 6'h2d;  5'h03: t6 = 6'h31;
      5'h04: t6 = 6'h35;  5'h05: t6 = 6'h29;  5'h06: t6 = 6'h19;  5'h07: t6 = 6'h38;
      5'h08: t6 = 6'h39;  5'h09: t6 = 6'h25;  5'h0a: t6 = 6'h15;  5'h0b: t6 = 6'h34;
      5'h0c: t6 = 6'h0d;  5'h0d: t6 = 6'h2c;  5'h0e: t6 = 6'h1c;  5'h0f: t6 = 6'h17;
      5'h10: t6 = 6'h1b;  5'h11: t6 = 6'h23;  5'h12: t6 = 6'h13;  5'h13: t6 = 6'h32;
      5'h14: t6 = 6'h0b;  5'h15: t6 = 6'h2a;  5'h16: t6 = 6'h1a;  5'h17: t6 = 6'h3a;
      5'h18: t6 = 6'h33;  5'h19: t6 = 6'h26;  5'h1a: t6 = 6'h16;  5'h1b: t6 = 6'h36;
      5'h1c: t6 = 6'h0e;  5'h1d: t6 = 6'h2e;  5'h1e: t6 = 6'h1e;  default: t6 = 6'h2b;
    endcase
    if (k28)
    begin
      t6 = 6'h0f;
    end
    unbal6 = ($countones(t6) != 3);
    if (rd && (unbal6 || x == 5'h07))
    begin
      t6 = ~t6;
    end
    rd1 = unbal6 ? ~rd : rd;
    alt7 = (y == 3'h7) && (k || (!rd1 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
                           (rd1 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
    case (y)
      3'h0: t4 = 4'hb;  3'h1: t4 = 4'h9;  3'h2: t4 = 4'h5;  3'h3: t4 = 4'hc;
      3'h4: t4 = 4'hd;  3'h5: t4 = 4'ha;  3'h6: t4 = 4'h6;  default: t4 = 4'he;
    endcase
    if (alt7)
    begin
      t4 = 4'h7;
    end
    unbal4 = ($countones(t4) != 2);
    if (rd1 && (unbal4 || y == 3'h3))
    begin
      t4 = ~t4;
    end
    // K28 special characters other than K28.3 invert their balanced tail too when the six-bit part left disparity negative
    if (k28 && !rd1 && !unbal4 && y != 3'h3)
    begin
      t4 = ~t4;
    end
    return {unbal4 ? ~rd1 : rd1, stxp_rev10({t6, t4})};
  endfunction
endpackage

// [verilog/stxp_tx.sv]
// transmit coding path: input buffer, byte serializer, encoder, bit stages, serializer
`timescale 1ns/100ps
`include "stxp_map.svh"

module stxp_fifo
  import stxp_pkg::*;
#(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data,
  // occupancy
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
  } stxp_fifo_state_s;

  stxp_fifo_state_s s;
  stxp_fifo_state_s next_s;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] stxp_ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign o_ready = (s.count != CW'(DEPTH));
  assign o_valid = (s.count != '0);
  assign o_data  = s.mem[s.rd_ptr];
  assign o_count = s.count;
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wr_ptr] = i_data;
      next_s.wr_ptr = stxp_ptr_inc(s.wr_ptr);
    end
    if (pop)
    begin
      next_s.rd_ptr = stxp_ptr_inc(s.rd_ptr);
    end
    next_s.count = CW'(s.count + CW'(push) - CW'(pop));
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule

module stxp_tx
  import stxp_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
)
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // transmit digital reset, active high level
  input  wire logic        i_tx_digital_reset,
  // ahb-lite register slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // fabric parallel words
  input  wire logic        i_valid,
  output logic             o_ready,
  input  stxp_word_s       i_word,
  // serial bits, [0] on the rising half, [1] on the falling half
  output logic [1:0]       o_ser_bits,
  output logic             o_word_start
);
  localparam int WW = $bits(stxp_word_s);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  stxp_state_s s;
  stxp_state_s next_s;
  stxp_word_s  push_word;
  stxp_word_s  head;
  logic        head_valid;
  logic        pop;
  logic [CW-1:0] fifo_count;
  logic        pclk_en;
  logic        wide;
  logic        split8;
  logic        avail;
  logic        use_hi;
  logic [9:0]  sym;
  logic        sym_k;
  logic        sym_force;
  logic        sym_dispval;
  logic        rd_use;
  logic [10:0] coded;
  logic [9:0]  pol_w;
  logic [9:0]  rev_w;
  logic [9:0]  load_w;
  logic [3:0]  slip_n;
  logic        addr_ok;

  // byte-level flip happens before buffering so the buffer holds what will be sent
  always_comb
  begin
    push_word = i_word;
    if (s.cfg.bitflip)
    begin
      push_word.data = {i_word.data[19:16], stxp_rev8(i_word.data[15:8]),
                        stxp_rev8(i_word.data[7:0])};  // [RULE14]
    end
  end

  stxp_fifo #(
    .WIDTH (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_valid   (i_valid),
    .o_ready   (o_ready),
    .i_data    (push_word),
    .o_valid   (head_valid),
    .i_ready   (pop),
    .o_data    (head),
    .o_count   (fifo_count)
  );

  // internal word is ten bits whenever the encoder runs [RULE18]
  assign wide    = s.cfg.width10 || s.cfg.enc;
  assign split8  = s.cfg.enc || !s.cfg.width10;
  assign pclk_en = (s.pair_cnt == (wide ? `STXP_LAST_PAIR10 : `STXP_LAST_PAIR8));
  assign avail   = head_valid && !i_tx_digital_reset && (s.commas == 2'h0);
  assign use_hi  = s.cfg.byteser && s.half;
  // the wide word leaves the buffer only once its upper half is taken [RULE1] [RULE2]
  assign pop     = pclk_en && avail && (!s.cfg.byteser || s.half);

  // lower half first, upper half on the next parallel cycle [RULE3]
  always_comb
  begin
    if (split8)
    begin
      sym = use_hi ? {2'h0, head.data[15:8]} : {2'h0, head.data[7:0]};
    end
    else
    begin
      sym = use_hi ? head.data[19:10] : head.data[9:0];
    end
    sym_k       = head.ctrl[use_hi];
    sym_force   = head.force_disp[use_hi];
    sym_dispval = head.disp_val[use_hi];
  end

  // dispval low forces positive, high negative [RULE10]
  assign rd_use = (avail && sym_force) ? ~sym_dispval : s.rd;
  // control flag picks the special table; with the encoder on, idle time is filled with commas [RULE4] [RULE5]
  assign coded  = avail ? stxp_encode(sym[7:0], sym_k, rd_use)
                        : stxp_encode(`STXP_K285_BYTE, 1'b1, s.rd);

  // polarity, reversal and slip stages in front of the serializer
  always_comb
  begin
    pol_w = s.cfg.polinv ? ~s.enc : s.enc;  // [RULE11]
    if (!wide)
    begin
      pol_w[9:8] = 2'h0;
    end
    if (!s.cfg.bitrev)
    begin
      rev_w = pol_w;
    end
    else if (wide)
    begin
      rev_w = stxp_rev10(pol_w);  // [RULE13]
    end
    else
    begin
      rev_w = {2'h0, stxp_rev8(pol_w[7:0])};  // [RULE13]
    end
    // older bits fill the low end, so the stream is late by slip_n bits [RULE15]
    if (wide)
    begin
      slip_n = (s.cfg.slip > 4'h9) ? 4'h9 : s.cfg.slip;
      load_w = 10'({rev_w, s.prev} >> (5'd10 - 5'(slip_n)));
    end
    else
    begin
      slip_n = (s.cfg.slip > 4'h7) ? 4'h7 : s.cfg.slip;
      load_w = {2'h0, 8'({rev_w[7:0], s.prev[7:0]} >> (5'd8 - 5'(slip_n)))};
    end
  end

  assign addr_ok = i_hsel && i_htrans[1] && i_hready;

  always_comb
  begin
    next_s = s;
    // register writes land in the data phase; unmapped writes fall away
    next_s.wr_pend = addr_ok && i_hwrite;
    if (addr_ok)
    begin
      next_s.wr_addr = i_haddr[7:0];
    end
    if (s.wr_pend && s.wr_addr == `STXP_ADDR_CTRL)
    begin
      next_s.cfg.byteser = i_hwdata[`STXP_CTRL_BYTESER];
      next_s.cfg.enc     = i_hwdata[`STXP_CTRL_ENC];
      next_s.cfg.width10 = i_hwdata[`STXP_CTRL_WIDTH10];
      next_s.cfg.bitrev  = i_hwdata[`STXP_CTRL_BITREV];
      next_s.cfg.bitflip = i_hwdata[`STXP_CTRL_BITFLIP];
      next_s.cfg.polinv  = i_hwdata[`STXP_CTRL_POLINV];
    end
    if (s.wr_pend && s.wr_addr == `STXP_ADDR_SLIP)
    begin
      next_s.cfg.slip = i_hwdata[3:0];
    end
    next_s.rdata = 32'h0;
    if (addr_ok && !i_hwrite)
    begin
      case (i_haddr[7:0])
        `STXP_ADDR_CTRL:
        begin
          next_s.rdata[`STXP_CTRL_BYTESER] = s.cfg.byteser;
          next_s.rdata[`STXP_CTRL_ENC]     = s.cfg.enc;
          next_s.rdata[`STXP_CTRL_WIDTH10] = s.cfg.width10;
          next_s.rdata[`STXP_CTRL_BITREV]  = s.cfg.bitrev;
          next_s.rdata[`STXP_CTRL_BITFLIP] = s.cfg.bitflip;
          next_s.rdata[`STXP_CTRL_POLINV]  = s.cfg.polinv;
        end
        `STXP_ADDR_SLIP:   next_s.rdata[3:0] = s.cfg.slip;
        `STXP_ADDR_STATUS: next_s.rdata[7:0] = {4'(fifo_count), 1'b0, s.half, s.commas != 2'h0, s.rd};
        default:           next_s.rdata = 32'h0;
      endcase
    end

    // divider: one parallel word per four or five clocks of two bits each
    next_s.pair_cnt = pclk_en ? 3'h0 : 3'(s.pair_cnt + 3'h1);
    if (s.pair_cnt > `STXP_LAST_PAIR10)
    begin
      next_s.pair_cnt = 3'h0;
    end
    if (!s.cfg.byteser)
    begin
      next_s.half = 1'b0;
    end

    if (pclk_en)
    begin
      if (i_tx_digital_reset)
      begin
        // inputs ignored, negative comma repeated [RULE7]
        next_s.enc    = `STXP_K285_NEG;
        next_s.rd     = 1'b0;
        next_s.commas = `STXP_SYNC_COMMAS;
        next_s.half   = 1'b0;
      end
      else if (s.commas != 2'h0)
      begin
        // three sync commas from negative disparity, words already in the pipe go first [RULE8] [RULE9]
        next_s.enc    = coded[9:0];
        next_s.rd     = coded[10];
        next_s.commas = 2'(s.commas - 2'h1);
      end
      else
      begin
        if (!s.cfg.enc)
        begin
          next_s.enc = avail ? (wide ? sym : {2'h0, sym[7:0]}) : 10'h0;
        end
        else
        begin
          next_s.enc = coded[9:0];
          next_s.rd  = coded[10];  // [RULE19]
        end
        if (avail && s.cfg.byteser)
        begin
          next_s.half = ~s.half;
        end
      end
      next_s.prev    = rev_w;
      // bit 0 leaves first, top bit last [RULE16]
      next_s.ser_out = load_w[1:0];
      next_s.shift   = load_w[9:2];
    end
    else
    begin
      next_s.ser_out = s.shift[1:0];  // [RULE17]
      next_s.shift   = {2'h0, s.shift[7:2]};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      s         <= '0;
      s.cfg     <= stxp_cfg_s'({6'(`STXP_CTRL_RST), `STXP_SLIP_RST});
      s.commas  <= `STXP_SYNC_COMMAS;
      s.enc     <= `STXP_K285_NEG;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_hrdata     = s.rdata;
  assign o_hreadyout  = 1'b1;
  assign o_hresp      = 1'b0;
  assign o_ser_bits   = s.ser_out;
  assign o_word_start = (s.pair_cnt == 3'h0);

  a_reset_comma: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RULE7]
    (pclk_en && i_tx_digital_reset) |=> (s.enc == `STXP_K285_NEG) && !s.rd && (s.commas == 2'h3))
    else $error("encoder did not hold negative comma in reset");

  a_sync_commas: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RULE8]
    (pclk_en && !i_tx_digital_reset && s.commas == 2'h3 && !s.rd)
      |=> (s.enc == `STXP_K285_NEG) && s.rd && (s.commas == 2'h2) && !$past(pop))
    else $error("first sync comma not negative");

  a_second_comma: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RULE8]
    (pclk_en && !i_tx_digital_reset && s.commas == 2'h2 && s.rd)
      |=> (s.enc == `STXP_K285_POS) && !s.rd && (s.commas == 2'h1))
    else $error("second sync comma not positive");

  a_byteser_halves: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RULE3]
    (pclk_en && avail && s.cfg.byteser && !s.half && !i_tx_digital_reset)
      |-> !pop && (sym[7:0] == head.data[7:0]) ##1 s.half)
    else $error("byte serializer did not take lower half first");

  a_force_disp: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RULE10]
    (pclk_en && avail && s.cfg.enc && sym_force)
      |=> {s.rd, s.enc} == $past(stxp_encode(sym[7:0], sym_k, ~sym_dispval)))
    else $error("forced disparity not applied");

  a_rd_follows: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RULE19]
    (pclk_en && avail && s.cfg.enc && sym_force)
      |=> (s.rd != $past(rd_use)) == ($countones(s.enc) != 5))
    else $error("running disparity not taken from sent group");

  a_polarity_load: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RULE11]
    (pclk_en && wide && !s.cfg.bitrev && s.cfg.slip == 4'h0)
      |=> {s.shift, s.ser_out} == ($past(s.cfg.polinv) ? ~$past(s.enc) : $past(s.enc)))
    else $error("polarity stage wrong");

  a_bit_reverse: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RULE13]
    (pclk_en && wide && s.cfg.bitrev && !s.cfg.polinv && s.cfg.slip == 4'h0)
      |=> s.ser_out[0] == $past(s.enc[9]) && s.shift[7] == $past(s.enc[0]))
    else $error("bit reversal wrong");

  a_slip_one: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RULE15]
    (pclk_en && wide && s.cfg.slip == 4'h1 && !s.cfg.bitrev && !s.cfg.polinv)
      |=> s.ser_out[0] == $past(s.prev[9]) && {s.shift, s.ser_out[1]} == $past(s.enc[8:0]))
    else $error("bit slip of one wrong");

  a_serial_order: assert property (@(posedge i_clk) disable iff (!i_reset_n)  // [RULE16]
    (pclk_en && wide) |=> (o_ser_bits == $past(load_w[1:0])) ##1 (o_ser_bits == $past(load_w[3:2], 2))
      ##1 (o_ser_bits == $past(load_w[5:4], 3)))
    else $error("serial order not lsb first");
endmodule

// [tb/stxp_fabric_model.sv]
// behavioural fabric source feeding parallel words into the transmit path
`timescale 1ns/100ps

module stxp_fabric_model
  import stxp_pkg::*;
(
  // clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_reset_n,
  // word stream
  input  wire logic  i_ready,
  output logic       o_valid,
  output stxp_word_s o_word
);
  stxp_word_s q[$];
  logic       stall = 1'b0;
  logic       taken;

  // callers raise the control flag only on valid special bytes
  task automatic push(input stxp_word_s wd);
    q.push_back(wd);
  endtask

  initial
  begin
    o_valid = 1'b0;
    o_word = '0;
  end

  // a word stays put until the edge that takes it, stall never drops a held word
  always @(posedge i_clk)
  begin
    taken = o_valid && i_ready && i_reset_n;
    if (taken)
    begin
      void'(q.pop_front());
    end
    o_valid <= (o_valid && !taken) || (!stall && q.size() > 0 && i_reset_n);
    if (q.size() > 0)
    begin
      o_word <= q[0];
    end
  end
endmodule

// [tb/stxp_tx_tb_top.sv]
// self-checking bench of the transmit coding path
`timescale 1ns/100ps
`include "stxp_map.svh"

module stxp_tx_tb_top
  import stxp_pkg::*;
;
  localparam stxp_word_s w_d215 = {20'hb5, 6'h0};
  localparam stxp_word_s w_d285 = {20'hbc, 6'h0};
  localparam stxp_word_s w_k = {20'hbc, 2'h1, 4'h0};
  localparam stxp_word_s w_kfp = {20'hbc, 2'h1, 2'h1, 2'h0};
  localparam stxp_word_s w_kfn = {20'hbc, 2'h1, 2'h1, 2'h1};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tx_rst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        valid;
  logic        ready;
  stxp_word_s  word;
  logic [1:0]  ser;
  logic        wstart;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          w = 10;
  int          k = 0;
  logic [9:0]  acc = '0;
  logic [9:0]  seen[$];
  logic [31:0] rd;

  initial
  begin
    forever #5 clk = ~clk;
  end

  stxp_tx DUT (.i_clk(clk), .i_reset_n(rst_n), .i_tx_digital_reset(tx_rst),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .i_valid(valid), .o_ready(ready), .i_word(word), .o_ser_bits(ser),
    .o_word_start(wstart));

  stxp_fabric_model fab (.i_clk(clk), .i_reset_n(rst_n), .i_ready(ready), .o_valid(valid), .o_word(word));

  // rebuild words two bits a cycle, earlier bit in position k; junk words are just skipped
  always @(posedge clk)
  begin
    if (wstart === 1'b1)
    begin
      if (k == w)
      begin
        seen.push_back(acc);
      end
      k = 0;
      acc = '0;
    end
    if (k < 9)
    begin
      acc[k] = ser[0];
      acc[k+1] = ser[1];
    end
    k = k + 2;
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // waits for the answer however long it takes; only the watchdog ends a hang
  task automatic wait_rdy();
    do
    begin
      @(posedge clk);
    end
    while (hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  // latency-free check: the expected words must appear back to back somewhere in the capture
  task automatic find(input logic [9:0] e[$]);
    int hit;
    int m;
    hit = 0;
    for (int i = 0; i + e.size() <= seen.size(); i++)
    begin
      m = 0;
      foreach (e[j])
        if (seen[i+j] === e[j]) m++;
      if (m == e.size()) hit = 1;
    end
    check("word sequence", hit, 1);
  endtask

  task automatic run(input logic [31:0] cfg, input int wd, input stxp_word_s ws[$], input logic [9:0] e[$]);
    bus(1'b1, `STXP_ADDR_CTRL, cfg);
    w = wd;
    repeat (60) @(posedge clk);
    seen.delete();
    foreach (ws[i])
      fab.push(ws[i]);
    repeat (200) @(posedge clk);
    find(e);
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk("ctrl", `STXP_ADDR_CTRL, `STXP_CTRL_RST);
    rdchk("slip", `STXP_ADDR_SLIP, 32'h0);
    bus(1'b1, 8'h0c, 32'hffff_ffff);
    rdchk("unmapped", 8'h0c, 32'h0);
    // fill while held in reset, stall the source for a while
    tx_rst <= 1'b1;
    fab.stall = 1'b1;
    repeat (9) fab.push(w_d215);
    seen.delete();
    repeat (20) @(posedge clk);
    fab.stall = 1'b0;
    repeat (40) @(posedge clk);
    check("ready full", {31'h0, ready}, 32'h0);
    bus(1'b0, `STXP_ADDR_STATUS, 32'h0);
    check("fill count", {28'h0, rd[7:4]}, 32'h8);
    find('{10'h17c, 10'h17c, 10'h17c, 10'h17c});
    tx_rst <= 1'b0;
    repeat (150) @(posedge clk);
    find('{10'h17c, 10'h283, 10'h17c, 10'h155, 10'h155});
    check("ready drained", {31'h0, ready}, 32'h1);
    run(32'h6, 10, '{w_kfp, w_k, w_d215, w_d285, w_kfn, w_k},
        '{10'h283, 10'h17c, 10'h155, 10'h15c, 10'h17c, 10'h283});
    run(32'h26, 10, '{w_d215, w_d215}, '{10'h2aa, 10'h2aa});
    run(32'he, 10, '{w_kfn, w_d215}, '{10'h0fa, 10'h2aa});
    run(32'h7, 10, '{{20'hbcb5, 6'h0}, {20'hbcb5, 6'h0}},
        '{10'h155, 10'h15c, 10'h155, 10'h15c});
    run(32'h17, 10, '{{20'h3dad, 6'h0}, {20'h3dad, 6'h0}},
        '{10'h155, 10'h15c, 10'h155, 10'h15c});
    run(32'h4, 10, '{{20'h2b3, 6'h0}, {20'h2b3, 6'h0}}, '{10'h2b3, 10'h2b3});
    run(32'h0, 8, '{{20'h5a, 6'h0}, {20'h5a, 6'h0}}, '{10'h05a, 10'h05a});
    bus(1'b1, `STXP_ADDR_SLIP, 32'h1);
    rdchk("slip", `STXP_ADDR_SLIP, 32'h1);
    run(32'h6, 10, '{w_d215, w_d215, w_d215}, '{10'h2aa, 10'h2aa});
    report_and_stop();
  end
endmodule
